// File: core/i2c_pkg.sv
// Shared constants for the two-wire register access link.
// Assumes both ends and the bench import it; no clock or reset lives here.
package i2c_pkg;
  localparam logic [6:0] ADDR_OPEN = 7'h66;
  localparam logic [6:0] ADDR_GND = 7'h65;
  localparam logic [6:0] ADDR_VDD = 7'h67;
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VDD = 2'h1;
  localparam logic [1:0] STRAP_OPEN = 2'h2;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] INIT_REG = 8'h09;
  localparam logic [7:0] INIT_VAL_A = 8'h02;
  localparam logic [7:0] INIT_VAL_B = 8'h00;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_PERIOD_NS = 400;
  localparam int SCL_HALF_CYC = SCL_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int BIT_LAST = 7;
  localparam int BYTE_BITS = 8;
endpackage

// File: core/i2c_link_if.sv
// Two-wire link between the register slave and the host master.
// Assumes a pull-up: a line is low when either party enables its driver low.
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_oe_n_m;
  logic sda_oe_n_m;
  logic sda_oe_n_s;
  wire scl = scl_oe_n_m;
  wire sda = sda_oe_n_m & sda_oe_n_s;
  modport slave (input scl, input sda, output sda_oe_n_s);
  modport master (input scl, input sda, output scl_oe_n_m, output sda_oe_n_m);
endinterface

// File: core/pin_sync.sv
// Three-stage synchroniser with agreement filter for pins from another domain.
// Assumes clk is the local clock; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync
  import i2c_pkg::*;
#(
  parameter logic INIT = 1'b1
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic pin,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  wire agree = (s2_q == s3_q);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level <= INIT;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree)
        level <= s3_q;
    end
  end
endmodule // pin_sync

// File: core/i2c_reg_slave.sv
// Two-wire register slave: decodes a strapped address, acks, keeps a pointer.
// Assumes an external byte register store answering reads in the same cycle.
// Function
// R1: first byte is address plus direction LSB
// R2: open strap answers base 66h (CCh)
// R3: strap low 65h, strap high 67h
// R4: master starts with SDA falling, SCL high
// R5: write direction bit is zero
// R6: ack every byte after matching address
// R7: master releases SDA during ack clock
// R8: master sends pointer then data bytes
// R9: each written byte advances pointer
// R10: read is pointer write, stop, then read
// R11: read returns byte at stored pointer
// R12: each read byte advances pointer
// R13: master ends a read with stop
// R14: host writes 02h then 00h to 09h
// R15: no ack on foreign address
// R16: repeated start aborts byte, keeps pointer
`timescale 1ns/1ps
module i2c_reg_slave
  import i2c_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  i2c_link_if.slave link,
  input wire logic [1:0] strap,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic busy
);
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WDATA, S_WDATA_ACK,
    S_RDATA, S_RDATA_ACK, S_IGNORE} state_t;
  state_t state_q;
  state_t state_d;
  logic scl;
  logic sda;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [6:0] base_q;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic rw_q;
  logic rw_d;
  logic sda_oe_n_q;
  logic sda_oe_n_d;
  logic wr_en_d;

  pin_sync #(.INIT(1'b1)) u_scl (.clk(clk), .srst(srst), .pin(link.scl), .level(scl));
  pin_sync #(.INIT(1'b1)) u_sda (.clk(clk), .srst(srst), .pin(link.sda), .level(sda));

  wire scl_rise = scl & ~scl_prev_q;
  wire scl_fall = ~scl & scl_prev_q;
  wire start_seen = scl & scl_prev_q & sda_prev_q & ~sda; // R4
  wire stop_seen = scl & scl_prev_q & ~sda_prev_q & sda;
  wire byte_done = (cnt_q == 3'(BIT_LAST));
  wire [7:0] shift_in = {shift_q[6:0], sda};
  wire addr_match = (shift_in[7:1] == base_q); // R1
  wire [6:0] strap_base = (strap == STRAP_GND) ? ADDR_GND :
                          (strap == STRAP_VDD) ? ADDR_VDD : ADDR_OPEN; // R2 R3

  // The strap is caught after reset release, never under the reset itself.
  always_ff @(posedge clk)
  begin
    if (srst)
      base_q <= ADDR_OPEN;
    else if (state_q == S_IDLE)
      base_q <= strap_base;
  end

  always_comb
  begin
    state_d = state_q;
    ptr_d = ptr_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    rw_d = rw_q;
    sda_oe_n_d = sda_oe_n_q;
    wr_en_d = 1'b0;
    if (start_seen)
    begin
      state_d = S_ADDR; // R16
      cnt_d = '0;
      sda_oe_n_d = 1'b1;
    end
    else if (stop_seen)
    begin
      state_d = S_IDLE;
      sda_oe_n_d = 1'b1;
    end
    else
    begin
      case (state_q)
        S_ADDR, S_PTR, S_WDATA:
          if (scl_rise)
          begin
            shift_d = shift_in;
            cnt_d = cnt_q + 3'h1;
            if (byte_done)
            begin
              if (state_q == S_ADDR)
              begin
                rw_d = shift_in[0];
                state_d = addr_match ? S_ADDR_ACK : S_IGNORE; // R15
              end
              else if (state_q == S_PTR)
              begin
                ptr_d = shift_in; // R8
                state_d = S_PTR_ACK;
              end
              else
              begin
                wr_en_d = 1'b1;
                state_d = S_WDATA_ACK;
              end
            end
          end
        S_ADDR_ACK, S_PTR_ACK, S_WDATA_ACK:
          if (scl_fall)
          begin
            if (sda_oe_n_q)
              sda_oe_n_d = 1'b0; // R6
            else
            begin
              sda_oe_n_d = 1'b1;
              cnt_d = '0;
              if (state_q == S_ADDR_ACK && rw_q == DIR_READ)
              begin
                state_d = S_RDATA; // R11
                shift_d = rd_data;
                sda_oe_n_d = rd_data[BIT_LAST];
                cnt_d = 3'h1;
              end
              else if (state_q == S_ADDR_ACK)
                state_d = S_PTR; // R5
              else
              begin
                if (state_q == S_WDATA_ACK)
                  ptr_d = ptr_q + 8'h01; // R9
                state_d = S_WDATA;
              end
            end
          end
        S_RDATA_ACK:
          if (scl_rise)
          begin
            // The pointer moves past every byte handed out, the last one too.
            ptr_d = ptr_q + 8'h01; // R12
            if (sda)
              state_d = S_IDLE; // R7
          end
          else if (scl_fall)
          begin
            // Only an acked byte gets here; the next register goes out at once.
            state_d = S_RDATA; // R12
            shift_d = rd_data;
            sda_oe_n_d = rd_data[BIT_LAST];
            cnt_d = 3'h1;
          end
        S_RDATA:
          if (scl_fall)
          begin
            if (cnt_q == '0)
            begin
              state_d = S_RDATA_ACK;
              sda_oe_n_d = 1'b1;
            end
            else
            begin
              sda_oe_n_d = shift_q[3'(BIT_LAST) - cnt_q];
              cnt_d = cnt_q + 3'h1;
            end
          end
        S_IGNORE:
          state_d = S_IGNORE;
        default:
          state_d = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= S_IDLE;
      ptr_q <= '0;
      shift_q <= '0;
      cnt_q <= '0;
      rw_q <= DIR_WRITE;
      sda_oe_n_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      busy <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ptr_q <= ptr_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      rw_q <= rw_d;
      sda_oe_n_q <= sda_oe_n_d;
      scl_prev_q <= scl;
      sda_prev_q <= sda;
      wr_en <= wr_en_d;
      wr_addr <= ptr_q;
      wr_data <= shift_in;
      busy <= (state_d != S_IDLE);
    end
  end

  // Master acks by driving low; the read ack state holds released until then.
  assign link.sda_oe_n_s = sda_oe_n_q;
  assign rd_addr = ptr_q;
endmodule // i2c_reg_slave

// File: core/i2c_host_master.sv
// Host end: runs pointer writes, data writes and reads over the two-wire link.
// Assumes single-byte commands; after reset it first runs the start-up writes.
`timescale 1ns/1ps
module i2c_host_master
  import i2c_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  i2c_link_if.master link,
  input wire logic [6:0] dev_addr,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mstate_t;
  mstate_t st_q;
  logic [$clog2(SCL_HALF_CYC+1)-1:0] tick_q;
  logic [1:0] phase_q;
  logic scl_q;
  logic sda_q;
  logic [7:0] sh_q;
  logic [2:0] bit_q;
  logic [1:0] idx_q;
  logic [1:0] nbytes_q;
  logic rd_q;
  logic seq_rd_q;
  logic [1:0] init_q;
  logic nack_q;
  logic [7:0] reg_q;
  logic [7:0] dat_q;
  logic sda_in;

  // The data line is driven from the far end too, so it passes the same filter.
  pin_sync #(.INIT(1'b1)) u_sda (.clk(clk), .srst(srst), .pin(link.sda), .level(sda_in));

  wire tick = (tick_q == '0);
  wire [7:0] addr_byte = {dev_addr, rd_q}; // R1
  // Read: pointer write, stop, then read transfer. Write: addr, pointer, data.
  wire [7:0] next_byte = (idx_q == 2'h0) ? addr_byte : (idx_q == 2'h1) ? reg_q : dat_q; // R8 R10
  wire last_byte = (idx_q + 2'h1 == nbytes_q);
  wire want_cmd = (init_q != 2'h2) || cmd_valid;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= M_IDLE;
      tick_q <= '0;
      phase_q <= '0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sh_q <= '0;
      bit_q <= '0;
      idx_q <= '0;
      nbytes_q <= '0;
      rd_q <= DIR_WRITE;
      seq_rd_q <= 1'b0;
      init_q <= '0;
      nack_q <= 1'b0;
      reg_q <= '0;
      dat_q <= '0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_nack <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      cmd_ready <= (st_q == M_IDLE) && (init_q == 2'h2) && !seq_rd_q;
      tick_q <= tick ? ($bits(tick_q))'(SCL_HALF_CYC - 1) : tick_q - 1'b1;
      if (tick)
      begin
        phase_q <= phase_q + 2'h1;
        case (st_q)
          M_IDLE:
          begin
            phase_q <= '0;
            if (seq_rd_q)
            begin
              rd_q <= DIR_READ;
              nbytes_q <= 2'h2;
              st_q <= M_START;
            end
            else if (want_cmd)
            begin
              // R14
              reg_q <= (init_q != 2'h2) ? INIT_REG : cmd_reg;
              dat_q <= (init_q == 2'h0) ? INIT_VAL_A : (init_q == 2'h1) ? INIT_VAL_B : cmd_data;
              seq_rd_q <= (init_q == 2'h2) && cmd_read;
              rd_q <= DIR_WRITE; // R5
              nbytes_q <= ((init_q == 2'h2) && cmd_read) ? 2'h2 : 2'h3;
              if (init_q != 2'h2)
                init_q <= init_q + 2'h1;
              st_q <= M_START;
            end
          end
          M_START:
          begin
            sda_q <= 1'b0; // R4
            st_q <= M_BIT;
            idx_q <= '0;
            bit_q <= '0;
            nack_q <= 1'b0;
            phase_q <= '0;
          end
          M_BIT, M_ACK:
          begin
            if (phase_q == 2'h0)
            begin
              scl_q <= 1'b0;
            end
            else if (phase_q == 2'h1)
            begin
              if (st_q == M_ACK)
                sda_q <= !(rd_q && idx_q != 2'h0 && !last_byte) ; // R7
              else if (rd_q && idx_q != 2'h0)
                sda_q <= 1'b1;
              else
                sda_q <= next_byte[3'(BIT_LAST) - bit_q];
              scl_q <= 1'b1;
            end
            else if (phase_q == 2'h2)
            begin
              phase_q <= '0;
              if (st_q == M_BIT)
              begin
                sh_q <= {sh_q[6:0], sda_in};
                bit_q <= bit_q + 3'h1;
                if (bit_q == 3'(BIT_LAST))
                  st_q <= M_ACK;
              end
              else
              begin
                if (rd_q && idx_q != 2'h0)
                begin
                  rsp_valid <= 1'b1;
                  rsp_data <= sh_q;
                end
                else if (sda_in)
                  nack_q <= 1'b1; // R15
                if (last_byte || (sda_in && !(rd_q && idx_q != 2'h0)))
                  st_q <= M_STOP; // R13
                else
                begin
                  idx_q <= idx_q + 2'h1;
                  st_q <= M_BIT;
                end
              end
            end
          end
          M_STOP:
          begin
            if (phase_q == 2'h0)
              scl_q <= 1'b0;
            else if (phase_q == 2'h1)
              sda_q <= 1'b0;
            else if (phase_q == 2'h2)
              scl_q <= 1'b1;
            else
            begin
              sda_q <= 1'b1;
              rsp_nack <= nack_q;
              if (rd_q)
                seq_rd_q <= 1'b0;
              if (nack_q)
                seq_rd_q <= 1'b0;
              st_q <= M_IDLE;
            end
          end
          default:
            st_q <= M_IDLE;
        endcase
      end
    end
  end

  assign link.scl_oe_n_m = scl_q;
  assign link.sda_oe_n_m = sda_q;
endmodule // i2c_host_master

// File: tb/i2c_link_monitor.sv
// Checker for the two-wire link between the host end and the register slave.
// Assumes the bench wires it to the link's lines, their driver enables, clk and srst.
`timescale 1ns/1ps
module i2c_link_monitor
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_n_m,
  input wire logic sda_oe_n_m,
  input wire logic sda_oe_n_s
);
  logic scl_q;
  logic sda_q;
  logic byte0_q;
  logic rd_q;
  logic ack_q;
  logic end_q;
  logic [3:0] bit_q;
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire rise_w = scl & ~scl_q;
  wire nine_w = rise_w & (bit_q == 4'h8);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // The bit count restarts at every start, so a repeated start realigns it.
  always_ff @(posedge clk)
  begin
    scl_q <= srst | scl;
    sda_q <= srst | sda;
    if (srst || start_w)
    begin
      bit_q <= 4'h0;
      byte0_q <= 1'b1;
      ack_q <= 1'b0;
      end_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (rise_w)
    begin
      bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
      if (byte0_q && bit_q == 4'h7)
        rd_q <= sda;
      if (byte0_q && bit_q == 4'h8)
        ack_q <= ~sda;
      if (bit_q == 4'h8)
        byte0_q <= 1'b0;
      // A nack ends the transfer, so the clock rise of the stop is no data bit.
      if (bit_q == 4'h8 && sda)
        end_q <= 1'b1;
    end
  end

  a_start_by_master: assert property (start_w |-> !sda_oe_n_m)
    else $error("start not made by the master");
  a_addr_slave_quiet: assert property (rise_w && byte0_q && bit_q < 4'h8 |-> sda_oe_n_s)
    else $error("slave drives during the address bits");
  a_ack_master_free: assert property (nine_w && (byte0_q || !rd_q) |-> sda_oe_n_m)
    else $error("master holds data during the acknowledge");
  a_ack_every_byte: assert property (nine_w && !byte0_q && !rd_q && ack_q |-> !sda_oe_n_s)
    else $error("written byte not acknowledged");
  a_read_master_free: assert property (rise_w && rd_q && !byte0_q && !end_q && bit_q < 4'h8 |-> sda_oe_n_m)
    else $error("master drives during read data");
  a_slave_steady_high: assert property (scl && scl_q |-> $stable(sda_oe_n_s))
    else $error("slave changes data while the clock is high");
  a_ack_held_low: assert property (nine_w && byte0_q && !sda |=> !sda [*8])
    else $error("address acknowledge not held");
  a_read_ends_nack: assert property (nine_w && rd_q && !byte0_q |-> sda)
    else $error("last read byte acknowledged by the master");
endmodule // i2c_link_monitor

// File: tb/testbench.sv
// Self-checking bench joining the host end and the register slave over one link.
// Assumes the host runs its start-up writes after reset; the bench models the byte store.
`timescale 1ns/1ps
module testbench;
  import i2c_pkg::*;
  logic clk = 1'b0;
  logic srst;
  logic [1:0] strap;
  logic [6:0] dev_addr;
  logic cmd_valid;
  logic cmd_read;
  logic [7:0] cmd_reg;
  logic [7:0] cmd_data;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic busy;
  logic [7:0] mem [256];
  logic [15:0] wlog [$];
  int rsp_n = 0;
  int error_cnt = 0;
  int check_count = 0;
  logic scl_p = 1'b1;
  logic sda_p = 1'b1;
  logic first_q = 1'b0;
  logic [3:0] nb = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] addr_byte = 8'h00;
  logic busy_seen = 1'b0;

  always #2 clk = ~clk;

  i2c_link_if i2c_link_if_i ();
  i2c_reg_slave i2c_reg_slave_i (.clk(clk), .srst(srst), .link(i2c_link_if_i.slave), .strap(strap),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
  i2c_host_master i2c_host_master_i (.clk(clk), .srst(srst), .link(i2c_link_if_i.master),
    .dev_addr(dev_addr), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_reg(cmd_reg),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  i2c_link_monitor i2c_link_monitor_i (.clk(clk), .srst(srst), .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
    .scl_oe_n_m(i2c_link_if_i.scl_oe_n_m), .sda_oe_n_m(i2c_link_if_i.sda_oe_n_m),
    .sda_oe_n_s(i2c_link_if_i.sda_oe_n_s));

  assign rd_data = mem[rd_addr];

  always @(posedge clk)
  begin
    if (wr_en === 1'b1)
    begin
      mem[wr_addr] <= wr_data;
      wlog.push_back({wr_addr, wr_data});
    end
    if (rsp_valid === 1'b1)
      rsp_n++;
    if (busy === 1'b1)
      busy_seen <= 1'b1;
  end

  // Captures the first byte on the wire after each start, MSB first.
  always @(posedge clk)
  begin
    scl_p <= i2c_link_if_i.scl;
    sda_p <= i2c_link_if_i.sda;
    if (i2c_link_if_i.scl && scl_p && sda_p && !i2c_link_if_i.sda)
    begin
      first_q <= 1'b1;
      nb <= 4'h0;
    end
    else if (i2c_link_if_i.scl && !scl_p && first_q)
    begin
      sh <= {sh[6:0], i2c_link_if_i.sda};
      nb <= nb + 4'h1;
      if (nb == 4'h7)
      begin
        addr_byte <= {sh[6:0], i2c_link_if_i.sda};
        first_q <= 1'b0;
      end
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_ready !== lvl && n < 30000);
    check("cmd_ready", {7'h00, lvl}, {7'h00, cmd_ready});
  endtask

  task automatic run_cmd(input logic rd, input logic [7:0] r, input logic [7:0] d);
    wait_ready(1'b1);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= r;
    cmd_data <= d;
    wait_ready(1'b0);
    cmd_valid <= 1'b0;
    wait_ready(1'b1);
    repeat (2) @(posedge clk);
  endtask

  task automatic test_init();
    wait_ready(1'b1);
    check("init writes", 8'h02, 8'(wlog.size()));
    check("init reg a", 8'h09, wlog[0][15:8]);
    check("init val a", 8'h02, wlog[0][7:0]);
    check("init reg b", 8'h09, wlog[1][15:8]);
    check("init val b", 8'h00, wlog[1][7:0]);
    check("init addr byte", 8'hCC, addr_byte);
    check("busy seen", 8'h01, {7'h00, busy_seen});
  endtask

  task automatic test_straps();
    logic [1:0] st [4] = '{STRAP_GND, STRAP_VDD, STRAP_OPEN, 2'h3};
    logic [6:0] da [4] = '{ADDR_GND, ADDR_VDD, ADDR_OPEN, ADDR_OPEN};
    logic [7:0] ab [4] = '{8'hCA, 8'hCE, 8'hCC, 8'hCC};
    for (int k = 0; k < 4; k++)
    begin
      strap <= st[k];
      dev_addr <= da[k];
      run_cmd(1'b0, 8'h20 + 8'(k), 8'h5A + 8'(k));
      check("addr byte", ab[k], addr_byte);
      check("write reg", 8'h20 + 8'(k), wlog[$][15:8]);
      check("write data", 8'h5A + 8'(k), wlog[$][7:0]);
      check("write ptr", 8'h21 + 8'(k), rd_addr);
      check("write nack", 8'h00, {7'h00, rsp_nack});
    end
  endtask

  task automatic test_foreign();
    int n;
    n = wlog.size();
    strap <= STRAP_GND;
    run_cmd(1'b0, 8'h30, 8'h77);
    check("foreign nack", 8'h01, {7'h00, rsp_nack});
    check("foreign writes", 8'(n), 8'(wlog.size()));
    strap <= STRAP_OPEN;
  endtask

  task automatic test_read();
    int n;
    n = rsp_n;
    run_cmd(1'b1, 8'h21, 8'h00);
    check("read addr byte", 8'hCD, addr_byte);
    check("read data", 8'h5B, rsp_data);
    check("read count", 8'h01, 8'(rsp_n - n));
    check("read ptr", 8'h22, rd_addr);
    run_cmd(1'b1, 8'hFF, 8'h00);
    check("read top", 8'hC3, rsp_data);
    check("read nack", 8'h00, {7'h00, rsp_nack});
    // The slave sees the stop only after its input filter has settled.
    repeat (8) @(posedge clk);
    check("busy idle", 8'h00, {7'h00, busy});
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    #240000;
    error_cnt++;
    $display("mismatch watchdog expected done seen running");
    results();
  end

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h3C;
    srst = 1'b1;
    strap = STRAP_OPEN;
    dev_addr = ADDR_OPEN;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 8'h00;
    cmd_data = 8'h00;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    test_init();
    test_straps();
    test_foreign();
    test_read();
    results();
  end
endmodule // testbench
